// >>> rtl/fps_pkg.sv
// Purpose: Shared constants and types of the flash program sequencer.
// Assumes: 125 MHz system clock; 8-bit processor writes.
// Notes:   Times are in ns; cycle counts derive from them.

package fps_pkg;

  // ----------------------------------------------------------------
  // Unlock keys
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_KEY_FIRST = 8'hAE;
  localparam logic [7:0] DATA_KEY_SECOND = 8'h56;
  localparam logic [7:0] PROG_KEY_FIRST = 8'h56;
  localparam logic [7:0] PROG_KEY_SECOND = 8'hAE;

  // ----------------------------------------------------------------
  // Control and status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_INV_RESET = 8'hFF;
  localparam logic [7:0] CTRL_ONE_MASK = 8'h0F;
  localparam logic [7:0] CTRL_TWO_MASK = 8'hF1;
  localparam logic [7:0] CTRL_TWO_MODES = 8'h71;
  localparam int CR1_FIX = 0;
  localparam int CR1_IE = 1;
  localparam int CR2_BLOCK = 0;
  localparam int CR2_FAST = 4;
  localparam int CR2_WIPE = 5;
  localparam int CR2_WORD = 6;
  localparam int CR2_CFG = 7;
  localparam int STAT_PROG_UNLOCK = 1;
  localparam int STAT_DATA_UNLOCK = 3;
  localparam logic [7:0] WIPE_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] WORD_LAST = 8'h03;
  localparam logic [7:0] BLOCK_LAST = 8'h7F;
  localparam int CLK_MHZ = 125;
  localparam int T_ERASE_NS = 2000;
  localparam int T_WRITE_NS = 2000;
  localparam logic [15:0] ERASE_CYC = 16'((T_ERASE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WRITE_CYC = 16'((T_WRITE_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_MEM = 3'h0, TGT_CTRL_ONE = 3'h1, TGT_CTRL_TWO = 3'h2,
    TGT_CTRL_TWO_INV = 3'h3, TGT_DATA_KEY = 3'h4, TGT_PROG_KEY = 3'h5,
    TGT_STATUS = 3'h6, TGT_OTHER = 3'h7
  } fps_target_t;
  typedef enum logic [1:0] {
    AREA_PROG = 2'h0, AREA_DATA = 2'h1, AREA_CFG = 2'h2, AREA_NONE = 2'h3
  } fps_area_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_LOAD = 2'h1, ST_ERASE = 2'h2, ST_WRITE = 2'h3
  } fps_state_t;
  typedef enum logic [2:0] {
    MODE_BYTE = 3'h0, MODE_WORD = 3'h1, MODE_BLOCK = 3'h2,
    MODE_FAST = 3'h3, MODE_WIPE = 3'h4
  } fps_mode_t;
  typedef struct packed {
    logic valid;
    fps_target_t target;
    fps_area_t area;
    logic [15:0] addr;
    logic [7:0] data;
  } fps_cpu_req_t;
  typedef struct packed {
    logic erase;
    logic write;
    logic block;
    fps_area_t area;
    logic [15:0] addr;
    logic [31:0] word;
    logic [3:0] lanes;
  } fps_nvm_cmd_t;
  typedef struct packed {
    logic eop;
    logic wpv;
    logic hv_idle;
    logic prog_unlocked;
    logic data_unlocked;
    logic busy;
  } fps_status_t;

endpackage

// >>> rtl/fps_key_unlock.sv
// Purpose: Two-key unlock of one memory area.
// Assumes: Key writes are one-cycle strobes on the system clock.
// Notes:   A wrong second key locks until reset.

`timescale 1ns/1ps

module fps_key_unlock #(
  parameter logic [7:0] FIRST = 8'h00,
  parameter logic [7:0] SECOND = 8'h00,
  parameter bit RETRY_FIRST = 1'b1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic wr_in, // Key write strobe
  input wire logic [7:0] key_in, // Key value
  input wire logic relock_in, // Software relock strobe
  output logic unlocked_out // Area write enabled
);
  import fps_pkg::*;

  typedef enum logic [1:0] {
    KEY_FIRST = 2'h0, KEY_SECOND = 2'h1, KEY_OPEN = 2'h2, KEY_DEAD = 2'h3
  } fps_key_state_t;
  typedef struct packed {
    fps_key_state_t st;
  } fps_key_regs_t;

  fps_key_regs_t s;
  fps_key_regs_t next_s;

  // ----------------------------------------------------------------
  // Key compare sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    unique case (s.st)
      KEY_FIRST: begin
        if (wr_in) begin
          if (key_in == FIRST) begin
            next_s.st = KEY_SECOND;
          end else if (!RETRY_FIRST) begin
            next_s.st = KEY_DEAD;
          end
        end
      end
      KEY_SECOND: begin
        if (wr_in) begin
          next_s.st = (key_in == SECOND) ? KEY_OPEN : KEY_DEAD;
        end
      end
      KEY_OPEN: begin
        if (relock_in) begin
          next_s.st = KEY_FIRST;
        end
      end
      KEY_DEAD: begin
        next_s.st = KEY_DEAD;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '{st: KEY_FIRST};
    end else begin
      s <= next_s;
    end
  end

  assign unlocked_out = (s.st == KEY_OPEN);

endmodule

// >>> rtl/fps_op_timer.sv
// Purpose: Counts the cycles of one erase or write phase.
// Assumes: start_in pulses while idle or in the done cycle.
// Notes:   done_out pulses once after count_in cycles.

`timescale 1ns/1ps

module fps_op_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic start_in, // Start pulse
  input wire logic [WIDTH-1:0] count_in, // Phase length in cycles
  output logic done_out // Phase end pulse
);
  import fps_pkg::*;

  typedef struct packed {
    logic run;
    logic [WIDTH-1:0] left;
  } fps_tmr_regs_t;

  fps_tmr_regs_t s;
  fps_tmr_regs_t next_s;

  // Down counter
  always_comb begin
    next_s = s;
    // Done from state alone, so a restart on it forms no loop
    done_out = s.run && (s.left <= WIDTH'(1));
    if (start_in) begin
      next_s.run = 1'b1;
      next_s.left = count_in;
    end else if (done_out) begin
      next_s.run = 1'b0;
    end else if (s.run) begin
      next_s.left = s.left - WIDTH'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// >>> rtl/fps_sequencer.sv
// Purpose: Sequences byte, word and block program and erase.
// Assumes: Processor writes arrive as one-cycle request pulses.
// Notes:   Control bits are plain ports; no register bus.

`timescale 1ns/1ps

module fps_sequencer #(
  parameter int BLOCK_BYTES = 128
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  input wire fps_pkg::fps_cpu_req_t req_in, // Processor write
  input wire logic status_read_in, // Status read strobe
  input wire logic write_protect_in, // Target page protected
  input wire logic word_blank_in, // Target word erased
  input wire logic [6:0] buf_idx_in, // Block buffer read index
  output logic stall_out, // Hold processor
  output logic data_read_hold_out, // Data reads unavailable
  output logic irq_mask_out, // Mask processor interrupts
  output logic irq_out, // Flash interrupt
  output fps_pkg::fps_status_t status_out, // Program status
  output logic [7:0] ctrl_one_out, // Control one value
  output logic [7:0] ctrl_two_out, // Control two value
  output logic [7:0] ctrl_two_inv_out, // Control two inverse
  output fps_pkg::fps_nvm_cmd_t nvm_cmd_out, // Array command
  output logic [7:0] buf_byte_out // Block buffer byte
);
  import fps_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fps_state_t st;
    fps_mode_t mode;
    fps_area_t area;
    logic [15:0] base;
    logic [7:0] fill;
    logic [31:0] word;
    logic [3:0] lanes;
    logic erase_then_write;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] ncr2;
    logic cr2_pend;
    logic eop;
    logic wpv;
    logic hv_idle;
    logic irq;
    logic [7:0] rd;
  } fps_seq_regs_t;

  fps_seq_regs_t s;
  fps_seq_regs_t next_s;
  logic [7:0] block_buf [BLOCK_BYTES];
  logic buf_we;
  logic tmr_start;
  logic [15:0] tmr_cycles;
  logic tmr_done;
  logic prog_unlocked;
  logic data_unlocked;
  logic busy;
  logic block_op;
  logic mem_wr;
  logic ctrl_touch;
  logic area_ok;
  logic status_wr;
  fps_mode_t sel_mode;

  // ----------------------------------------------------------------
  // Unlock and timing helpers
  // ----------------------------------------------------------------
  assign status_wr = req_in.valid && (req_in.target == TGT_STATUS);

  // Program area keys; a wrong first key locks until reset
  fps_key_unlock #(
    .FIRST(PROG_KEY_FIRST),
    .SECOND(PROG_KEY_SECOND),
    .RETRY_FIRST(1'b0)
  ) u_prog_key (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(req_in.valid && (req_in.target == TGT_PROG_KEY)),
    .key_in(req_in.data),
    .relock_in(status_wr && !req_in.data[STAT_PROG_UNLOCK]),
    .unlocked_out(prog_unlocked)
  );

  // Data area keys; a wrong first key may be retried
  fps_key_unlock #(
    .FIRST(DATA_KEY_FIRST),
    .SECOND(DATA_KEY_SECOND),
    .RETRY_FIRST(1'b1)
  ) u_data_key (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(req_in.valid && (req_in.target == TGT_DATA_KEY)),
    .key_in(req_in.data),
    .relock_in(status_wr && !req_in.data[STAT_DATA_UNLOCK]),
    .unlocked_out(data_unlocked)
  );

  // Phase length counter
  fps_op_timer #(
    .WIDTH(16)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(tmr_start),
    .count_in(tmr_cycles),
    .done_out(tmr_done)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign busy = (s.st == ST_ERASE) || (s.st == ST_WRITE);
  assign block_op = (s.st != ST_IDLE) && (s.mode inside {MODE_BLOCK, MODE_FAST, MODE_WIPE});
  assign mem_wr = req_in.valid && (req_in.target == TGT_MEM) && !busy;
  assign ctrl_touch = req_in.valid &&
    (req_in.target inside {TGT_CTRL_ONE, TGT_CTRL_TWO});

  // Target area write permission
  always_comb begin
    unique case (req_in.area)
      AREA_PROG: area_ok = prog_unlocked;
      AREA_DATA: area_ok = data_unlocked;
      AREA_CFG: area_ok = data_unlocked && s.cr2[CR2_CFG] && !s.ncr2[CR2_CFG];
      default: area_ok = 1'b0;
    endcase
    area_ok = area_ok && !write_protect_in;
  end

  // Confirmed mode bit, fixed priority
  always_comb begin
    if (s.cr2[CR2_WIPE] && !s.ncr2[CR2_WIPE]) begin
      sel_mode = MODE_WIPE;
    end else if (s.cr2[CR2_BLOCK] && !s.ncr2[CR2_BLOCK]) begin
      sel_mode = MODE_BLOCK;
    end else if (s.cr2[CR2_FAST] && !s.ncr2[CR2_FAST]) begin
      sel_mode = MODE_FAST;
    end else if (s.cr2[CR2_WORD] && !s.ncr2[CR2_WORD]) begin
      sel_mode = MODE_WORD;
    end else begin
      sel_mode = MODE_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    buf_we = 1'b0;
    tmr_start = 1'b0;
    tmr_cycles = WRITE_CYC;

    // Flag clear first so a same-cycle set wins
    if (status_read_in) begin
      next_s.eop = 1'b0;
      next_s.wpv = 1'b0;
    end

    // Inverse must be the very next request
    if (req_in.valid && s.cr2_pend) begin
      next_s.cr2_pend = 1'b0;
      if (!((req_in.target == TGT_CTRL_TWO_INV) && (req_in.data == ~s.cr2))) begin
        next_s.cr2 = CTRL_TWO_RESET;
      end
    end

    // Control writes are dropped while the array is busy; stall holds control one and two
    if (req_in.valid && !busy) begin
      unique case (req_in.target)
        TGT_CTRL_ONE: next_s.cr1 = req_in.data & CTRL_ONE_MASK;
        TGT_CTRL_TWO: begin
          next_s.cr2 = req_in.data & CTRL_TWO_MASK;
          next_s.cr2_pend = 1'b1;
        end
        TGT_CTRL_TWO_INV: next_s.ncr2 = req_in.data | ~CTRL_TWO_MASK;
        default: ;
      endcase
    end

    // Refused memory writes leave the array untouched
    if (mem_wr && !area_ok) begin
      next_s.wpv = 1'b1;
      next_s.st = ST_IDLE;
    end

    unique case (s.st)
      ST_IDLE: begin
        if (mem_wr && area_ok) begin
          next_s.area = req_in.area;
          next_s.base = req_in.addr;
          next_s.fill = 8'h01;
          next_s.word = {4{req_in.data}};
          next_s.lanes = 4'h1 << req_in.addr[1:0];
          next_s.erase_then_write = s.cr1[CR1_FIX] || !word_blank_in;
          next_s.mode = (req_in.area == AREA_CFG) ? MODE_BYTE : sel_mode;
          unique case (next_s.mode)
            MODE_BYTE: begin
              // Any data, zero included, takes this path
              tmr_start = 1'b1;
              if (next_s.erase_then_write) begin
                next_s.st = ST_ERASE;
                tmr_cycles = ERASE_CYC;
              end else begin
                next_s.st = ST_WRITE;
                next_s.hv_idle = 1'b0;
              end
            end
            MODE_WORD: begin
              next_s.st = ST_LOAD;
            end
            MODE_BLOCK, MODE_FAST: begin
              buf_we = 1'b1;
              next_s.st = ST_LOAD;
            end
            MODE_WIPE: begin
              if ((req_in.addr[1:0] == 2'h0) && (req_in.data == WIPE_DATA)) begin
                next_s.st = ST_ERASE;
                tmr_start = 1'b1;
                tmr_cycles = ERASE_CYC;
              end
            end
            default: next_s.st = ST_IDLE;
          endcase
        end
      end
      ST_LOAD: begin
        if (mem_wr && area_ok) begin
          next_s.fill = s.fill + 8'h01;
          if (s.mode == MODE_WORD) begin
            // Each byte goes to the lane its low address bits pick, in any order
            next_s.word[8*req_in.addr[1:0] +: 8] = req_in.data;
            next_s.lanes = s.lanes | (4'h1 << req_in.addr[1:0]);
            if (s.fill == WORD_LAST) begin
              tmr_start = 1'b1;
              next_s.st = s.erase_then_write ? ST_ERASE : ST_WRITE;
              tmr_cycles = s.erase_then_write ? ERASE_CYC : WRITE_CYC;
              next_s.hv_idle = s.erase_then_write;
            end
          end else begin
            // Low address bits pick the byte in the block
            buf_we = 1'b1;
            if (s.fill == BLOCK_LAST) begin
              tmr_start = 1'b1;
              if (s.mode == MODE_FAST) begin
                next_s.st = ST_WRITE;
                next_s.hv_idle = 1'b0;
              end else begin
                next_s.st = ST_ERASE;
                tmr_cycles = ERASE_CYC;
              end
            end
          end
        end
      end
      ST_ERASE: begin
        if (tmr_done) begin
          if (s.mode == MODE_WIPE) begin
            next_s.st = ST_IDLE;
            next_s.eop = 1'b1;
          end else begin
            next_s.st = ST_WRITE;
            next_s.hv_idle = 1'b0;
            tmr_start = 1'b1;
          end
        end
      end
      ST_WRITE: begin
        if (tmr_done) begin
          next_s.st = ST_IDLE;
          next_s.eop = 1'b1;
          next_s.hv_idle = 1'b1;
        end
      end
    endcase

    // Operation end drops the one-shot mode bits
    if (busy && tmr_done && (next_s.st == ST_IDLE)) begin
      next_s.cr2 = next_s.cr2 & ~CTRL_TWO_MODES;
      next_s.ncr2 = next_s.ncr2 | CTRL_TWO_MODES;
    end

    // Flags raise the interrupt when enabled
    next_s.irq = next_s.cr1[CR1_IE] && (next_s.eop || next_s.wpv);

    // Control register read data
    next_s.rd = s.cr2;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '{st: ST_IDLE, mode: MODE_BYTE, area: AREA_NONE,
             cr1: CTRL_ONE_RESET, cr2: CTRL_TWO_RESET,
             ncr2: CTRL_TWO_INV_RESET, hv_idle: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Block buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (buf_we) begin
      block_buf[req_in.addr[6:0]] <= req_in.data;
    end
    buf_byte_out <= block_buf[buf_idx_in];
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Program area byte and word ops hold the core; block ops and data area ops run alongside
  assign stall_out = busy && (((s.area == AREA_PROG) && !block_op) || ctrl_touch);
  assign data_read_hold_out = busy && (s.area == AREA_PROG);
  assign irq_mask_out = block_op;
  assign irq_out = s.irq;
  assign ctrl_one_out = s.cr1;
  assign ctrl_two_out = s.rd;
  assign ctrl_two_inv_out = s.ncr2;

  // Status view
  always_comb begin
    status_out.eop = s.eop;
    status_out.wpv = s.wpv;
    status_out.hv_idle = s.hv_idle;
    status_out.prog_unlocked = prog_unlocked;
    status_out.data_unlocked = data_unlocked;
    status_out.busy = (s.st != ST_IDLE);
  end

  // Array command
  always_comb begin
    nvm_cmd_out.erase = (s.st == ST_ERASE);
    nvm_cmd_out.write = (s.st == ST_WRITE);
    nvm_cmd_out.block = block_op;
    nvm_cmd_out.area = s.area;
    nvm_cmd_out.addr = block_op ? {s.base[15:7], 7'h00} : s.base;
    nvm_cmd_out.word = s.word;
    nvm_cmd_out.lanes = (s.mode == MODE_BYTE) ? s.lanes : 4'hF;
  end

endmodule

// >>> tb/fps_seq_properties.sv
// Purpose: Port assertions of the flash program sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the sequencer at the foot of this file.
`timescale 1ns/1ps
module fps_seq_chk #(
  parameter int BLOCK_BYTES = 128
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire fps_pkg::fps_cpu_req_t req_in, // Processor write
  input wire logic write_protect_in, // Page protected
  input wire logic word_blank_in, // Word erased
  input wire logic stall_out, // Processor hold
  input wire logic data_read_hold_out, // Data reads held
  input wire logic irq_mask_out, // Interrupt mask
  input wire logic irq_out, // Flash interrupt
  input wire fps_pkg::fps_status_t status_out, // Status
  input wire logic [7:0] ctrl_one_out, // Control one
  input wire logic [7:0] ctrl_two_out, // Control two
  input wire fps_pkg::fps_nvm_cmd_t nvm_cmd_out // Array command
);
  import fps_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  logic ctl_req;
  // Control register access
  assign ctl_req = req_in.valid && req_in.target inside {TGT_CTRL_ONE, TGT_CTRL_TWO};
  logic nvm_busy;
  // Array erase or write phase
  assign nvm_busy = nvm_cmd_out.erase || nvm_cmd_out.write;
  sequence s_two_set;
    req_in.valid && req_in.target == TGT_CTRL_TWO && !status_out.busy;
  endsequence
  sequence s_not_inv;
    req_in.valid && !(req_in.target inside {TGT_CTRL_TWO, TGT_CTRL_TWO_INV});
  endsequence
  sequence s_byte_start;
    $rose(status_out.busy) && nvm_cmd_out.lanes != 4'hF;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_STALL_CTRL: assert property (
    nvm_busy && ctl_req |-> stall_out) else $error("control access not stalled");
  AST_PROG_STALL: assert property (
    nvm_busy && nvm_cmd_out.area == AREA_PROG && !nvm_cmd_out.block
    |-> stall_out && data_read_hold_out) else $error("program area op not stalled");
  AST_DATA_RUN: assert property (
    status_out.busy && nvm_cmd_out.area != AREA_PROG && !ctl_req |-> !stall_out)
    else $error("data area op stalled");
  AST_MASK: assert property (
    status_out.busy && nvm_cmd_out.block |-> irq_mask_out) else $error("irq not masked");
  AST_IRQ: assert property (
    (status_out.eop || status_out.wpv) && ctrl_one_out[CR1_IE] |-> irq_out)
    else $error("irq missing");
  AST_EOP: assert property (
    $fell(nvm_cmd_out.write) |-> status_out.eop) else $error("eop missing");
  AST_HV: assert property (
    $rose(nvm_cmd_out.write) |-> !status_out.hv_idle) else $error("hv idle not cleared");
  AST_FIX: assert property (
    s_byte_start and ctrl_one_out[CR1_FIX] |-> nvm_cmd_out.erase) else $error("no erase");
  AST_BLANK: assert property (
    s_byte_start and !ctrl_one_out[CR1_FIX] && $past(word_blank_in)
    |-> (nvm_cmd_out.write && !nvm_cmd_out.erase) [*8]) else $error("blank word erased");
  AST_TWO: assert property (
    s_two_set ##1 !req_in.valid ##1 s_not_inv |-> ##2 ctrl_two_out == 8'h00)
    else $error("control two kept");
  AST_MODES: assert property (
    $fell(status_out.busy) |-> ##1 (ctrl_two_out & CTRL_TWO_MODES) == 8'h00)
    else $error("mode bits kept");
endmodule
bind fps_sequencer fps_seq_chk #(.BLOCK_BYTES(BLOCK_BYTES)) u_chk (.clk_in(clk_in),
  .rst_in(rst_in), .req_in(req_in), .write_protect_in(write_protect_in),
  .word_blank_in(word_blank_in), .stall_out(stall_out),
  .data_read_hold_out(data_read_hold_out), .irq_mask_out(irq_mask_out), .irq_out(irq_out),
  .status_out(status_out), .ctrl_one_out(ctrl_one_out), .ctrl_two_out(ctrl_two_out),
  .nvm_cmd_out(nvm_cmd_out));

// >>> tb/fps_cpu_model.sv
// Purpose: Processor model issuing byte writes to the sequencer.
// Assumes: One request at a time, launched at a rising edge.
// Notes:   Released data shows inverted value, never the last one.
`timescale 1ns/1ps
module fps_cpu_model (
  input wire logic clk_in, // System clock
  input wire logic stall_in, // Sequencer hold
  output fps_pkg::fps_cpu_req_t req_out // Write request
);
  import fps_pkg::*;
  initial req_out = '{1'b0, TGT_OTHER, AREA_NONE, 16'h0000, 8'h00};
  // Write held until an edge without stall, then released
  task automatic put(input fps_target_t t, input fps_area_t a, input logic [15:0] ad,
    input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, t, a, ad, d};
    @(posedge clk_in);
    while (stall_in) @(posedge clk_in);
    req_out.valid <= 1'b0;
    req_out.data <= ~d;
  endtask
endmodule

// >>> tb/tb.sv
// Purpose: Self-checking bench of the flash program sequencer.
// Assumes: 125 MHz clock; processor model makes all writes.
// Notes:   Each scenario is one task; flags cleared after each op.
`timescale 1ns/1ps
module tb;
  import fps_pkg::*;
  logic clk_in, rst_in, status_read_in, write_protect_in, word_blank_in, stall, hold, mask, irq;
  logic [6:0] buf_idx_in;
  logic [7:0] c1, c2, c2i, bb;
  fps_cpu_req_t req;
  fps_status_t st;
  fps_nvm_cmd_t nv;
  int fails, check_count;
  // ------------------------------------------------------------
  // Design, processor model, clock
  // ------------------------------------------------------------
  fps_sequencer dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .status_read_in(status_read_in), .write_protect_in(write_protect_in),
    .word_blank_in(word_blank_in), .buf_idx_in(buf_idx_in), .stall_out(stall),
    .data_read_hold_out(hold), .irq_mask_out(mask), .irq_out(irq), .status_out(st),
    .ctrl_one_out(c1), .ctrl_two_out(c2), .ctrl_two_inv_out(c2i), .nvm_cmd_out(nv),
    .buf_byte_out(bb));
  fps_cpu_model cpu (.clk_in(clk_in), .stall_in(stall), .req_out(req));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic mw(input fps_area_t a, input logic [15:0] ad, input logic [7:0] d);
    cpu.put(TGT_MEM, a, ad, d);
  endtask
  task automatic rw(input fps_target_t t, input logic [7:0] d);
    cpu.put(t, AREA_NONE, 16'h0000, d);
  endtask
  task automatic clr;
    @(posedge clk_in);
    status_read_in <= 1'b1;
    @(posedge clk_in);
    status_read_in <= 1'b0;
  endtask
  // Op length up to the done flag, then interrupt and clear
  task automatic done(input logic [31:0] exp, input logic ie);
    int n;
    n = 1;
    while (st.eop !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    chk("cycles", n, exp);
    step(1);
    chk("irq", irq, ie);
    clr();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_locked;
    fps_area_t ar[3] = '{AREA_DATA, AREA_CFG, AREA_PROG};
    foreach (ar[i]) begin
      mw(ar[i], 16'h0010, 8'h55);
      step(1);
      chk("wpv", st.wpv, 1'b1);
      chk("write", nv.write, 1'b0);
      clr();
    end
  endtask
  task automatic t_byte;
    rw(TGT_DATA_KEY, 8'hAE);
    rw(TGT_DATA_KEY, 8'h56);
    step(1);
    chk("unlocked", st.data_unlocked, 1'b1);
    rw(TGT_CTRL_ONE, 8'h02);
    mw(AREA_DATA, 16'h0021, 8'h3C);
    step(1);
    chk("write", nv.write, 1'b1);
    chk("erase", nv.erase, 1'b0);
    chk("stall", stall, 1'b0);
    done(32'(WRITE_CYC), 1'b1);
    word_blank_in <= 1'b0;
    mw(AREA_DATA, 16'h0022, 8'h00);
    step(1);
    chk("erase", nv.erase, 1'b1);
    done(32'(ERASE_CYC) + 32'(WRITE_CYC), 1'b1);
    write_protect_in <= 1'b1;
    mw(AREA_DATA, 16'h0024, 8'h11);
    step(1);
    chk("wpv", st.wpv, 1'b1);
    chk("write", nv.write, 1'b0);
    step(1);
    chk("irq", irq, 1'b1);
    write_protect_in <= 1'b0;
    clr();
  endtask
  task automatic t_fix_word;
    rw(TGT_CTRL_ONE, 8'h01);
    word_blank_in <= 1'b1;
    mw(AREA_DATA, 16'h0028, 8'h77);
    step(1);
    chk("erase", nv.erase, 1'b1);
    done(32'(ERASE_CYC) + 32'(WRITE_CYC), 1'b0);
    rw(TGT_CTRL_TWO, 8'h40);
    rw(TGT_CTRL_ONE, 8'h00);
    step(2);
    chk("ctrl_two", c2, 8'h00);
    rw(TGT_CTRL_TWO, 8'h40);
    rw(TGT_CTRL_TWO_INV, 8'hBF);
    for (int i = 0; i < 4; i++) mw(AREA_DATA, 16'h0030 + 16'(i), 8'(i + 8'hA0));
    step(1);
    chk("lanes", nv.lanes, 4'hF);
    chk("word", nv.word, 32'hA3A2A1A0);
    done(32'(WRITE_CYC), 1'b0);
    chk("ctrl_two", c2, 8'h00);
  endtask
  task automatic t_block(input logic [7:0] m, input logic [15:0] base, input logic er);
    rw(TGT_CTRL_TWO, m);
    rw(TGT_CTRL_TWO_INV, ~m);
    for (int i = 0; i < 128; i++) mw(AREA_DATA, base | 16'(i), 8'(i + 1));
    step(1);
    chk("erase", nv.erase, er);
    chk("addr", nv.addr, base);
    chk("mask", mask, 1'b1);
    chk("hv_idle", st.hv_idle, er);
    done(er ? 32'(ERASE_CYC) + 32'(WRITE_CYC) : 32'(WRITE_CYC), 1'b0);
    buf_idx_in <= 7'h05;
    step(1);
    chk("buf", bb, 8'h06);
    chk("ctrl_two", c2, 8'h00);
  endtask
  task automatic t_wipe_prog_cfg;
    rw(TGT_CTRL_TWO, 8'h20);
    rw(TGT_CTRL_TWO_INV, 8'hDF);
    mw(AREA_DATA, 16'h0085, 8'h00);
    step(1);
    chk("busy", st.busy, 1'b0);
    mw(AREA_DATA, 16'h0084, 8'h00);
    step(1);
    chk("wipe", {nv.erase, nv.block, mask}, 3'h7);
    done(32'(ERASE_CYC), 1'b0);
    rw(TGT_PROG_KEY, 8'h56);
    rw(TGT_PROG_KEY, 8'hAE);
    mw(AREA_PROG, 16'h8000, 8'h5A);
    step(1);
    chk("stall", {stall, hold}, 2'h3);
    done(32'(WRITE_CYC), 1'b0);
    rw(TGT_CTRL_TWO, 8'h80);
    rw(TGT_CTRL_TWO_INV, 8'h7F);
    mw(AREA_CFG, 16'h4800, 8'hA5);
    step(1);
    chk("cfg", {nv.write, stall}, 2'h2);
    done(32'(WRITE_CYC), 1'b0);
    mw(AREA_CFG, 16'h4801, 8'h5A);
    rw(TGT_CTRL_ONE, 8'h02);
    step(1);
    chk("held", {st.eop, c1}, 9'h102);
    clr();
  endtask
  task automatic print_verdict;
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {rst_in, status_read_in, write_protect_in, word_blank_in} = 4'h9;
    buf_idx_in = 7'h00;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    step(1);
    chk("reset", {c1, c2, c2i, 7'h00, st.hv_idle}, 32'h0000FF01);
    t_locked();
    t_byte();
    t_fix_word();
    t_block(8'h01, 16'h0100, 1'b1);
    t_block(8'h10, 16'h0180, 1'b0);
    t_wipe_prog_cfg();
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    fails++;
    print_verdict();
  end
endmodule
